// ===== inc/gtc_params.svh
`ifndef GTC_PARAMS_SVH
`define GTC_PARAMS_SVH
// register byte offsets
`define GTC_OFS_CTRL 8'h00
`define GTC_OFS_SLAVE 8'h08
`define GTC_OFS_IEN 8'h0c
`define GTC_OFS_FLAG 8'h10
`define GTC_OFS_EVGEN 8'h14
`define GTC_OFS_CHCFG1 8'h18
`define GTC_OFS_CHCFG2 8'h1c
`define GTC_OFS_CHEN 8'h20
`define GTC_OFS_COUNT 8'h24
`define GTC_OFS_DIV 8'h28
`define GTC_OFS_RELOAD 8'h2c
`define GTC_OFS_CMP1 8'h34
`define GTC_OFS_AUX 8'h50
// field positions
`define GTC_CTRL_RUN 0
`define GTC_CTRL_ONEP 3
`define GTC_CTRL_DOWN 4
`define GTC_CTRL_RELOAD_PRELOAD_EN 7
`define GTC_AUX_DE 0
`define GTC_IEN_DMA 9
`define GTC_FLAG_OVC 9
// reset values
`define GTC_RST_RELOAD 16'hffff
// slave mode and trigger select codes
`define GTC_SM_RESET 3'h4
`define GTC_SM_TRIG 3'h6
`define GTC_SM_EXT 3'h7
`define GTC_TS_IN1_ANY 3'h4
`define GTC_TS_IN1 3'h5
`define GTC_TS_IN2 3'h6
// axi responses
`define GTC_RESP_OK 2'h0
`define GTC_RESP_ERR 2'h2
`endif

// ===== inc/gtc_pkg.sv
package gtc_pkg;
   typedef struct packed {
      logic [3:0] irq;
      logic [3:0] dma;
   } gtc_req_s;
   typedef enum logic {GTC_UP, GTC_DOWN} gtc_dir_e;
endpackage

// ===== rtl/gtc_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "gtc_params.svh"
module gtc_timer
#(
   parameter int CW = 16
)
(
   input wire logic aclk, // bus clock
   input wire logic aresetn, // sync reset
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic [3:0] chan_in, // channel input pins
   input wire logic [3:0] internal_trigger_in, // sibling triggers
   input wire logic debug_mode, // system in debug
   input wire logic debug_freeze, // halt while debugging
   output logic [3:0] output_reference, // compare references
   output logic [3:0] chan_out, // channel output pins
   output logic trigger_output, // update pulse to siblings
   output gtc_pkg::gtc_req_s chan_req // irq and dma levels
);
   import gtc_pkg::*;

   // ==========================================================
   // functions
   function automatic logic [15:0] merge(input logic [15:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
      merge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
   endfunction

   function automatic logic trg_lvl(input logic [2:0] sel, input logic [1:0] f,
                                    input logic [1:0] p, input logic [3:0] itr);
      case (sel)
         `GTC_TS_IN1_ANY: trg_lvl = f[0];
         `GTC_TS_IN1: trg_lvl = f[0] ^ p[0];
         `GTC_TS_IN2: trg_lvl = f[1] ^ p[1];
         3'h0, 3'h1, 3'h2, 3'h3: trg_lvl = itr[sel[1:0]];
         default: trg_lvl = 1'b0;
      endcase
   endfunction

   // ==========================================================
   // registers
   logic [15:0] ctl_q, smc_q, ien_q, sr_q, psc_q, psc_sh_q, arr_q, arr_sh_q;
   logic [15:0] ccer_q, aux_q, de_start_q;
   logic [CW-1:0] core_counter_q;
   logic [15:0] ccr_q [4];
   logic [15:0] cmp_sh_q [4];
   logic [7:0] cm_q [4];
   logic [15:0] pc_q;
   logic [3:0] fl_q, fp_q, ref_q;
   logic [3:0] fc_q [4];
   logic [2:0] dv_q [4];
   logic [3:0] itr_q;
   logic run_q, chg_q;
   gtc_dir_e cdir_q;
   logic [3:0] rise, fall, pe, cap, sw_cap, is_in;
   logic [15:0] cap_val [4];

   // ==========================================================
   // axi4-lite slave
   logic aw_ok_q, w_ok_q, wr_fire, rd_fire;
   logic [7:0] wa_q;
   logic [31:0] wd_q;
   logic [3:0] ws_q;
   logic [3:0] rd_ccr;
   logic [15:0] rd_val;

   assign wr_fire = aw_ok_q & w_ok_q & ~s_axi_bvalid;
   assign rd_fire = s_axi_arvalid & s_axi_arready;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_ok_q <= 1'b0;
         w_ok_q <= 1'b0;
         wa_q <= '0;
         wd_q <= '0;
         ws_q <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `GTC_RESP_OK;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_ok_q <= 1'b1;
            wa_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ok_q <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire)
         begin
            aw_ok_q <= 1'b0;
            w_ok_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wa_q > `GTC_OFS_AUX || wa_q[1:0] != 2'h0) ?
                           `GTC_RESP_ERR : `GTC_RESP_OK;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_comb
   begin
      rd_val = 16'h0000;
      case (s_axi_araddr)
         `GTC_OFS_CTRL: rd_val = {ctl_q[15:1], run_q};
         `GTC_OFS_SLAVE: rd_val = smc_q;
         `GTC_OFS_IEN: rd_val = ien_q;
         `GTC_OFS_FLAG: rd_val = sr_q;
         `GTC_OFS_CHCFG1: rd_val = {cm_q[1], cm_q[0]};
         `GTC_OFS_CHCFG2: rd_val = {cm_q[3], cm_q[2]};
         `GTC_OFS_CHEN: rd_val = ccer_q;
         `GTC_OFS_COUNT: rd_val = core_counter_q;
         `GTC_OFS_DIV: rd_val = psc_q;
         `GTC_OFS_RELOAD: rd_val = arr_q;
         `GTC_OFS_CMP1: rd_val = ccr_q[0];
         `GTC_OFS_CMP1 + 8'h04: rd_val = ccr_q[1];
         `GTC_OFS_CMP1 + 8'h08: rd_val = ccr_q[2];
         `GTC_OFS_CMP1 + 8'h0c: rd_val = ccr_q[3];
         `GTC_OFS_AUX: rd_val = aux_q;
         default: rd_val = 16'h0000;
      endcase
   end

   always_comb
   begin
      for (int i = 0; i < 4; i++)
         rd_ccr[i] = rd_fire && s_axi_araddr == `GTC_OFS_CMP1 + 8'(4 * i);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `GTC_RESP_OK;
      end
      else if (rd_fire)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {16'h0000, rd_val};
         s_axi_rresp <= (s_axi_araddr > `GTC_OFS_AUX || s_axi_araddr[1:0] != 2'h0) ?
                        `GTC_RESP_ERR : `GTC_RESP_OK;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ==========================================================
   // configuration registers
   logic [15:0] wm;
   logic wr_ctl, wr_ug;
   assign wm = merge(16'h0000, wd_q, ws_q);
   assign wr_ctl = wr_fire && wa_q == `GTC_OFS_CTRL;
   assign wr_ug = wr_fire && wa_q == `GTC_OFS_EVGEN && ws_q[0] && wd_q[0];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctl_q <= '0;
         smc_q <= '0;
         ien_q <= '0;
         ccer_q <= '0;
         psc_q <= '0;
         arr_q <= `GTC_RST_RELOAD;
         aux_q <= '0;
         for (int i = 0; i < 4; i++)
         begin
            cm_q[i] <= '0;
            ccr_q[i] <= '0;
         end
      end
      else
      begin
         if (wr_ctl)
            ctl_q <= merge(ctl_q, wd_q, ws_q);
         if (wr_fire && wa_q == `GTC_OFS_SLAVE)
            smc_q <= merge(smc_q, wd_q, ws_q);
         if (wr_fire && wa_q == `GTC_OFS_IEN)
            ien_q <= merge(ien_q, wd_q, ws_q);
         if (wr_fire && wa_q == `GTC_OFS_CHEN)
            ccer_q <= merge(ccer_q, wd_q, ws_q);
         if (wr_fire && wa_q == `GTC_OFS_DIV)
            psc_q <= merge(psc_q, wd_q, ws_q);
         if (wr_fire && wa_q == `GTC_OFS_RELOAD)
            arr_q <= merge(arr_q, wd_q, ws_q);
         if (wr_fire && wa_q == `GTC_OFS_AUX)
            aux_q <= merge(aux_q, wd_q, ws_q);
         if (wr_fire && wa_q == `GTC_OFS_CHCFG1)
            {cm_q[1], cm_q[0]} <= merge({cm_q[1], cm_q[0]}, wd_q, ws_q);
         if (wr_fire && wa_q == `GTC_OFS_CHCFG2)
            {cm_q[3], cm_q[2]} <= merge({cm_q[3], cm_q[2]}, wd_q, ws_q);
         for (int i = 0; i < 4; i++)
            if (cap[i])
               ccr_q[i] <= cap_val[i];
            else if (wr_fire && wa_q == `GTC_OFS_CMP1 + 8'(4 * i))
               ccr_q[i] <= merge(ccr_q[i], wd_q, ws_q);
      end
   end

   // ==========================================================
   // input filter, edges, divider and capture
   logic [2:0] lim [4];
   logic de_on;
   assign de_on = aux_q[`GTC_AUX_DE] && cm_q[1][1:0] == 2'b11;
   assign rise = fl_q & ~fp_q;
   assign fall = ~fl_q & fp_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fl_q <= '0;
         fp_q <= '0;
         itr_q <= '0;
         for (int i = 0; i < 4; i++)
            fc_q[i] <= '0;
      end
      else
      begin
         fp_q <= fl_q;
         itr_q <= internal_trigger_in;
         for (int i = 0; i < 4; i++)
            if (chan_in[i] == fl_q[i])
               fc_q[i] <= '0;
            else if (fc_q[i] >= cm_q[i][7:4])
            begin
               fl_q[i] <= chan_in[i];
               fc_q[i] <= '0;
            end
            else
               fc_q[i] <= fc_q[i] + 4'h1;
      end
   end

   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         is_in[i] = cm_q[i][1:0] != 2'b00;
         sw_cap[i] = wr_fire && wa_q == `GTC_OFS_EVGEN && ws_q[0] && wd_q[i + 1];
         if (cm_q[i][1:0] == 2'b10)
            pe[i] = ccer_q[4 * i + 1] ? fall[i ^ 1] : rise[i ^ 1];
         else
            pe[i] = ccer_q[4 * i + 1] ? fall[i] : rise[i];
         lim[i] = 3'((1 << cm_q[i][3:2]) - 1);
         cap_val[i] = core_counter_q;
      end
      if (de_on)
      begin
         pe[1] = ccer_q[5] ? rise[1] : fall[1];
         cap_val[1] = core_counter_q - de_start_q;
      end
      for (int i = 0; i < 4; i++)
         cap[i] = is_in[i] && ccer_q[4 * i] && ((pe[i] && dv_q[i] == lim[i]) || sw_cap[i]);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         de_start_q <= '0;
         for (int i = 0; i < 4; i++)
            dv_q[i] <= '0;
      end
      else
      begin
         if (de_on && (ccer_q[5] ? fall[1] : rise[1]))
            de_start_q <= core_counter_q;
         for (int i = 0; i < 4; i++)
            if (!is_in[i] || !ccer_q[4 * i])
               dv_q[i] <= '0;
            else if (pe[i])
               dv_q[i] <= (dv_q[i] == lim[i]) ? 3'h0 : dv_q[i] + 3'h1;
      end
   end

   // ==========================================================
   // counter, prescaler, slave modes
   logic [2:0] sm;
   logic halt, t_now, t_old, trg, e1, e2, enc_up, enc_step, src_p, tick, step;
   logic up, ovf, update_event, at_end;
   logic [15:0] arr_eff;
   assign sm = smc_q[2:0];
   assign halt = debug_mode & debug_freeze;
   assign t_now = trg_lvl(smc_q[6:4], fl_q[1:0], {ccer_q[5], ccer_q[1]}, internal_trigger_in);
   assign t_old = trg_lvl(smc_q[6:4], fp_q[1:0], {ccer_q[5], ccer_q[1]}, itr_q);
   assign trg = smc_q[6:4] == `GTC_TS_IN1_ANY ? t_now ^ t_old : t_now & ~t_old;
   assign e1 = (sm == 3'h2 || sm == 3'h3) && (rise[0] | fall[0]);
   assign e2 = (sm == 3'h1 || sm == 3'h3) && (rise[1] | fall[1]);
   assign enc_up = e1 ? (rise[0] ? ~fl_q[1] : fl_q[1]) : (rise[1] ? fl_q[0] : ~fl_q[0]);
   assign enc_step = e1 | e2;
   assign src_p = sm == `GTC_SM_EXT ? trg : 1'b1;
   assign tick = run_q && !halt && sm != 3'h1 && sm != 3'h2 && sm != 3'h3 && src_p
                 && pc_q == psc_sh_q;
   assign step = tick | (run_q & ~halt & enc_step);
   assign arr_eff = ctl_q[`GTC_CTRL_RELOAD_PRELOAD_EN] ? arr_sh_q : arr_q;
   assign up = ctl_q[6:5] != 2'b00 ? cdir_q == GTC_UP :
               (enc_step ? enc_up : ~ctl_q[`GTC_CTRL_DOWN]);
   assign at_end = up ? core_counter_q >= arr_eff : core_counter_q == '0;
   assign ovf = step & at_end;
   assign update_event = ovf | wr_ug | (sm == `GTC_SM_RESET && trg);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         core_counter_q <= '0;
         pc_q <= '0;
         cdir_q <= GTC_UP;
         chg_q <= 1'b0;
      end
      else
      begin
         chg_q <= step | update_event;
         if (update_event && !ovf)
         begin
            core_counter_q <= '0;
            pc_q <= '0;
            cdir_q <= GTC_UP;
         end
         else
         begin
            if (run_q && !halt && src_p)
               pc_q <= (pc_q >= psc_sh_q) ? 16'h0000 : pc_q + 16'h0001;
            if (step && ctl_q[6:5] != 2'b00)
            begin
               core_counter_q <= up ? core_counter_q + 1'b1 : core_counter_q - 1'b1;
               if (up && core_counter_q + 1'b1 >= arr_eff)
                  cdir_q <= GTC_DOWN;
               else if (!up && core_counter_q == 16'h0001)
                  cdir_q <= GTC_UP;
            end
            else if (step)
               core_counter_q <= up ? (at_end ? '0 : core_counter_q + 1'b1)
                                    : (at_end ? arr_eff : core_counter_q - 1'b1);
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         run_q <= 1'b0;
      else if (ovf && ctl_q[`GTC_CTRL_ONEP])
         run_q <= 1'b0;
      else if (sm == `GTC_SM_TRIG && trg)
         run_q <= 1'b1;
      else if (wr_ctl && ws_q[0])
         run_q <= wd_q[`GTC_CTRL_RUN];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         psc_sh_q <= '0;
         arr_sh_q <= `GTC_RST_RELOAD;
         for (int i = 0; i < 4; i++)
            cmp_sh_q[i] <= '0;
      end
      else if (update_event)
      begin
         psc_sh_q <= psc_q;
         arr_sh_q <= arr_q;
         for (int i = 0; i < 4; i++)
            cmp_sh_q[i] <= ccr_q[i];
      end
      else
         for (int i = 0; i < 4; i++)
            if (!cm_q[i][3])
               cmp_sh_q[i] <= ccr_q[i];
   end

   // ==========================================================
   // compare, flags, outputs
   logic [3:0] m, cmp_ev, clr;
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         m[i] = chg_q && core_counter_q == cmp_sh_q[i];
         cmp_ev[i] = !is_in[i] && m[i] && (ctl_q[6:5] == 2'b00 || ctl_q[6:5] == 2'b11 ||
                     (ctl_q[6:5] == 2'b01) == (cdir_q == GTC_DOWN));
         clr[i] = (wr_fire && wa_q == `GTC_OFS_FLAG && ws_q[0] && !wm[i + 1]) || rd_ccr[i];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sr_q <= '0;
      else
      begin
         sr_q[0] <= update_event | (sr_q[0] & ~(wr_fire && wa_q == `GTC_OFS_FLAG && ws_q[0] && !wm[0]));
         for (int i = 0; i < 4; i++)
         begin
            sr_q[i + 1] <= cap[i] | cmp_ev[i] | (sr_q[i + 1] & ~clr[i]);
            sr_q[i + `GTC_FLAG_OVC] <= (cap[i] & sr_q[i + 1]) | (sr_q[i + `GTC_FLAG_OVC]
               & ~(wr_fire && wa_q == `GTC_OFS_FLAG && ws_q[1] && !wm[i + `GTC_FLAG_OVC]));
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ref_q <= '0;
      else
         for (int i = 0; i < 4; i++)
            case (cm_q[i][6:4])
               3'h1: if (m[i]) ref_q[i] <= 1'b1;
               3'h2: if (m[i]) ref_q[i] <= 1'b0;
               3'h3: if (m[i]) ref_q[i] <= ~ref_q[i];
               3'h4: ref_q[i] <= 1'b0;
               3'h5: ref_q[i] <= 1'b1;
               3'h6, 3'h7:
                  if (ctl_q[6:5] != 2'b00)
                  begin
                     if (m[i])
                        ref_q[i] <= ~ref_q[i];
                  end
                  else if (core_counter_q != cmp_sh_q[i])
                     ref_q[i] <= (core_counter_q > cmp_sh_q[i]) ^ cm_q[i][4];
               default: ref_q[i] <= ref_q[i];
            endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         output_reference <= '0;
         chan_out <= '0;
         trigger_output <= 1'b0;
         chan_req <= '0;
      end
      else
      begin
         output_reference <= ref_q;
         trigger_output <= update_event;
         for (int i = 0; i < 4; i++)
         begin
            chan_out[i] <= ccer_q[4 * i] && !is_in[i] && (ref_q[i] ^ ccer_q[4 * i + 1]);
            chan_req.irq[i] <= sr_q[i + 1] & ien_q[i + 1];
            chan_req.dma[i] <= sr_q[i + 1] & ien_q[i + `GTC_IEN_DMA];
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/gtc_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// pulse and encoder source at the channel pins
module gtc_pin_model
(
   input wire logic aclk, // bench clock
   output logic [3:0] chan_in, // channel pins
   output logic [3:0] internal_trigger_in // sibling triggers
);
   int p = 0;
   initial chan_in = 4'h0;
   initial internal_trigger_in = 4'h0;
   task automatic drive(input int i, input logic v, input int hold);
      @(posedge aclk);
      chan_in[i] <= v;
      repeat (hold) @(posedge aclk);
   endtask
   task automatic pulse(input int i, input int hold);
      drive(i, 1'b1, hold);
      drive(i, 1'b0, hold);
   endtask
   // gray steps on pins 0 and 1, pin 0 leads when fwd
   task automatic quad(input int steps, input logic fwd, input int hold);
      logic [1:0] g [4];
      g = '{2'h0, 2'h1, 2'h3, 2'h2};
      repeat (steps)
      begin
         p = fwd ? (p + 1) % 4 : (p + 3) % 4;
         @(posedge aclk);
         chan_in[1:0] <= g[p];
         repeat (hold) @(posedge aclk);
      end
   endtask
endmodule
`default_nettype wire

// ===== tb/gtc_timer_sva.sv
`timescale 1ns/1ns
`default_nettype none
module gtc_timer_chk
(
   input wire logic aclk, // clock
   input wire logic aresetn, // reset
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic s_axi_bvalid, // b valid
   input wire logic [7:0] s_axi_araddr, // ar address
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic s_axi_rvalid, // r valid
   input wire logic [1:0] s_axi_rresp, // r response
   input wire logic [31:0] s_axi_rdata, // r data
   input wire logic debug_mode, // debug
   input wire logic debug_freeze, // freeze
   input wire logic [3:0] output_reference, // references
   input wire logic trigger_output, // trigger
   input wire gtc_pkg::gtc_req_s chan_req // requests
);
   import gtc_pkg::*;
   logic [3:0] ev_q;
   wire logic ev = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
   // recent bus accesses, the only cause for a request to drop
   always_ff @(posedge aclk)
      ev_q <= aresetn ? {ev_q[2:0], ev} : 4'h0;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_answer;
      !s_axi_awready ##1 s_axi_bvalid;
   endsequence
   sequence s_frozen;
      (debug_mode && debug_freeze) [*6];
   endsequence
   wr_answer_a: assert property (s_wr_take |=> s_wr_answer)
      else $error("write answer late");
   rd_error_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h50
      |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   trig_pulse_a: assert property (trigger_output |=> !trigger_output)
      else $error("trigger longer than one cycle");
   freeze_quiet_a: assert property (s_frozen |-> !trigger_output && $stable(output_reference))
      else $error("timer moved while frozen");
   irq_fall_a: assert property (|($past(chan_req.irq) & ~chan_req.irq) |-> |ev_q)
      else $error("irq dropped without access");
   dma_fall_a: assert property (|($past(chan_req.dma) & ~chan_req.dma) |-> |ev_q)
      else $error("dma dropped without access");
endmodule
bind gtc_timer gtc_timer_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .s_axi_rdata, .debug_mode, .debug_freeze,
   .output_reference, .trigger_output, .chan_req);
`default_nettype wire

// ===== tb/gtc_timer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "gtc_params.svh"
module gtc_timer_tb_top;
   import gtc_pkg::*;
   logic aclk, aresetn, debug_mode, debug_freeze, trigger_output;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed, rv, v0, v1, c;
   logic [3:0] s_axi_wstrb, chan_in, internal_trigger_in, output_reference, chan_out;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   gtc_req_s chan_req;
   int failures, num_checks, hi, m, tg;
   gtc_timer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .chan_in, .internal_trigger_in, .debug_mode, .debug_freeze,
      .output_reference, .chan_out, .trigger_output, .chan_req);
   gtc_pin_model pins (.aclk, .chan_in, .internal_trigger_in);
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // ==========================================
   // checking and bus tasks
   task automatic test_done();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] up);
      num_checks++;
      if ((g >= lo && g <= up) !== 1'b1)
      begin
         failures++;
         $display("[FAIL] %0t got %0d outside %0d..%0d", $time, g, lo, up);
      end
   endtask
   task automatic tmo(input int k);
      if (k > 60)
      begin
         failures++;
         $display("[FAIL] %0t bus wait ran out", $time);
         test_done();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      int k;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      k = 0;
      do
      begin
         @(posedge aclk);
         k++;
         tmo(k);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      chk(s_axi_bresp, er);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
      int k;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      k = 0;
      do
      begin
         @(posedge aclk);
         k++;
         tmo(k);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      chk(s_axi_rresp, er);
      s_axi_rready <= 1'b0;
   endtask
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // high cycles of reference 0 over four periods of ten
   task automatic count_hi(input logic [31:0] lo, input logic [31:0] up);
      hi = 0;
      tg = 0;
      repeat (2) @(posedge aclk);
      repeat (40)
      begin
         @(posedge aclk);
         tg += (trigger_output === 1'b1);
         if (output_reference[0] === 1'b1)
            hi++;
      end
      chk_rng(hi, lo, up);
      chk(tg, 32'h4);
   endtask
   // ==========================================
   // main sequence
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {aresetn, debug_mode, debug_freeze} = 3'h0;
      s_axi_awaddr = 8'h0;
      s_axi_araddr = 8'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      seed = 32'h1fbaaac6;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`GTC_OFS_RELOAD, rv);
      chk(rv, `GTC_RST_RELOAD);
      rd(`GTC_OFS_CTRL, rv);
      chk(rv, 32'h0);
      rd(8'h54, rv, `GTC_RESP_ERR);
      chk(rv, 32'h0);
      wr(8'h54, 32'h1, `GTC_RESP_ERR);
      $display("register test done");
      c = 32'h1 + rnd() % 8;
      wr(`GTC_OFS_RELOAD, 32'h9);
      wr(`GTC_OFS_CMP1, c);
      wr(`GTC_OFS_CHEN, 32'h1);
      wr(`GTC_OFS_CHCFG1, 32'h40);
      wr(`GTC_OFS_CTRL, 32'h1);
      repeat (3) @(posedge aclk);
      chk({output_reference[0], chan_out[0]}, 2'b00);
      wr(`GTC_OFS_FLAG, 32'h0);
      repeat (12) @(posedge aclk);
      rd(`GTC_OFS_FLAG, rv);
      chk(rv & 32'h2, 32'h2);
      wr(`GTC_OFS_CHCFG1, 32'h50);
      repeat (3) @(posedge aclk);
      chk({output_reference[0], chan_out[0]}, 2'b11);
      $display("forced output test done");
      wr(`GTC_OFS_CHCFG1, 32'h60);
      wr(`GTC_OFS_EVGEN, 32'h1);
      count_hi(4 * (9 - c), 4 * (10 - c));
      wr(`GTC_OFS_CHCFG1, 32'h70);
      count_hi(4 * c, 4 * (c + 1));
      $display("pwm test done");
      wr(`GTC_OFS_CTRL, 32'h9);
      repeat (25) @(posedge aclk);
      rd(`GTC_OFS_CTRL, rv);
      chk(rv & 32'h1, 32'h0);
      $display("one pulse test done");
      wr(`GTC_OFS_RELOAD, 32'hffff);
      wr(`GTC_OFS_CHCFG1, 32'h1);
      wr(`GTC_OFS_FLAG, 32'h0);
      wr(`GTC_OFS_IEN, 32'h202);
      wr(`GTC_OFS_CTRL, 32'h1);
      rd(`GTC_OFS_COUNT, v0);
      pins.pulse(0, 4 + rnd() % 5);
      pins.pulse(0, 4 + rnd() % 5);
      rd(`GTC_OFS_COUNT, v1);
      rd(`GTC_OFS_FLAG, rv);
      chk(rv, 32'h202);
      chk(chan_req, 8'h11);
      rd(`GTC_OFS_CMP1, rv);
      chk_rng(rv, v0, v1);
      rd(`GTC_OFS_FLAG, rv);
      chk(rv, 32'h200);
      chk(chan_req, 8'h00);
      wr(`GTC_OFS_FLAG, 32'h0);
      wr(`GTC_OFS_EVGEN, 32'h2);
      rd(`GTC_OFS_FLAG, rv);
      chk(rv, 32'h2);
      rd(`GTC_OFS_CMP1, rv);
      wr(`GTC_OFS_CHEN, 32'h0);
      wr(`GTC_OFS_EVGEN, 32'h2);
      pins.pulse(0, 4 + rnd() % 5);
      rd(`GTC_OFS_FLAG, rv);
      chk(rv, 32'h0);
      $display("capture test done");
      wr(`GTC_OFS_CHCFG1, 32'h0101);
      for (m = 1; m <= 3; m++)
      begin
         wr(`GTC_OFS_SLAVE, m);
         rd(`GTC_OFS_COUNT, v0);
         pins.quad(4, 1'b1, 3 + rnd() % 4);
         rd(`GTC_OFS_COUNT, rv);
         chk(rv, (v0 + (m == 3 ? 4 : 2)) & 32'hffff);
         pins.quad(4, 1'b0, 3 + rnd() % 4);
         rd(`GTC_OFS_COUNT, rv);
         chk(rv, v0);
      end
      $display("encoder test done");
      wr(`GTC_OFS_CTRL, 32'h0);
      wr(`GTC_OFS_SLAVE, 32'h66);
      pins.pulse(1, 4 + rnd() % 5);
      rd(`GTC_OFS_CTRL, rv);
      chk(rv & 32'h1, 32'h1);
      wr(`GTC_OFS_SLAVE, 32'h0);
      $display("trigger start test done");
      @(posedge aclk);
      debug_mode <= 1'b1;
      debug_freeze <= 1'b1;
      repeat (3) @(posedge aclk);
      rd(`GTC_OFS_COUNT, v0);
      repeat (10) @(posedge aclk);
      rd(`GTC_OFS_COUNT, v1);
      chk(v1, v0);
      debug_freeze <= 1'b0;
      repeat (5) @(posedge aclk);
      rd(`GTC_OFS_COUNT, v1);
      chk(v1 !== v0, 1'b1);
      $display("debug test done");
      test_done();
   end
endmodule
`default_nettype wire
